// *** rtl/fp_state_pkg.sv ***
// Shared constants and types for the floating-point state and exception logic
// Notes on behaviour
// - Thirty-two 32-bit working registers; loads ignored in exception mode.
// - Doubles use even pair; extended uses aligned quad.
// - State bits 31:30 pick rounding direction.
// - State bits 29:28 pick extended rounding precision.
// - Enabled raised exception causes exception trap.
// - All five trap enable bits real; each reads back as loaded.
// - Abrupt underflow bit flushes denormal results.
// - Reserved state bits read zero; load zeros.
// - Bits 16:14 hold trap type until next completion or sequence error.
// - State load keeps trap type; store reads it.
// - Trapping exception freezes result, accrued; compare codes still set.
// - Unfinished/unimplemented leave accrued, codes, result.
// - Operate or load fetched in exception mode: sequence error.
// - Bit 13 shows queue not empty; drains.
// - Bits 11:10 compare codes, set even when trapping.
// - Compare codes: equal, less, greater, unordered.
// - Mask AND current: trap, else OR into accrued.
// - Bits 9:5 accumulate masked exceptions, load/store visible.
// - Bits 4:0 hold last operate's exceptions.
// - Exception conditions: invalid, overflow, tiny-inexact, divzero, inexact.
// - 32-bit product extension for multiply step.
// - Queue front holds faulting address and instruction.
package fp_state_pkg;
	// ****************************************
	// Register file geometry
	// ****************************************
	localparam int FREG_NUM = 32;
	localparam int FREG_W = 32;
	localparam int FIDX_W = 5;
	localparam int OPND_W = 128;
	localparam int XFER_W = 64;
	// ****************************************
	// State register field positions
	// ****************************************
	localparam int RD_LO = 30;
	localparam int RP_LO = 28;
	localparam int TEM_LO = 23;
	localparam int AU_BIT = 22;
	localparam int FTT_LO = 14;
	localparam int QNE_BIT = 13;
	localparam int FCC_LO = 10;
	localparam int AEXC_LO = 5;
	localparam int CEXC_LO = 0;
	localparam int EXC_W = 5;
	localparam logic [31:0] FSR_RESET = 32'h0000_0000;
	localparam logic [31:0] PEXT_RESET = 32'h0000_0000;
	// Exponent masks for the leading word of each precision
	localparam logic [31:0] SGL_EXP_MASK = 32'h7F80_0000;
	localparam logic [31:0] DBL_EXP_MASK = 32'h7FF0_0000;
	localparam logic [31:0] QUAD_EXP_MASK = 32'h7FFF_0000;
	localparam logic [31:0] SIGN_MASK = 32'h8000_0000;
	// ****************************************
	// Pending operation queue
	// ****************************************
	localparam int QUEUE_DEPTH = 4;
	localparam int QPTR_W = 2;
	localparam int QCNT_W = 3;
	localparam logic [QCNT_W-1:0] QCNT_ONE = 3'h1;
	localparam logic [QPTR_W-1:0] QPTR_ONE = 2'h1;
	// ****************************************
	// Enumerations
	// ****************************************
	typedef enum logic [1:0] {RD_NEAREST = 2'h0, RD_ZERO = 2'h1, RD_POS_INF = 2'h2,
		RD_NEG_INF = 2'h3} round_dir_t;
	typedef enum logic [1:0] {RP_EXTENDED = 2'h0, RP_SINGLE = 2'h1, RP_DOUBLE = 2'h2,
		RP_UNUSED = 2'h3} round_prec_t;
	typedef enum logic [2:0] {FTT_NONE = 3'h0, FTT_IEEE = 3'h1, FTT_UNFINISHED = 3'h2,
		FTT_UNIMPL = 3'h3, FTT_SEQ_ERR = 3'h4} ftt_t;
	typedef enum logic [1:0] {FCC_EQ = 2'h0, FCC_LT = 2'h1, FCC_GT = 2'h2,
		FCC_UNORD = 2'h3} fcc_t;
	typedef enum logic [1:0] {PREC_SINGLE = 2'h0, PREC_DOUBLE = 2'h1,
		PREC_QUAD = 2'h2} prec_t;
	typedef enum logic [1:0] {DONE_OK = 2'h0, DONE_UNFINISHED = 2'h1,
		DONE_UNIMPL = 2'h2} done_status_t;
	typedef enum logic [1:0] {ST_RUN = 2'b01, ST_EXC = 2'b10} fpu_state_t;
endpackage

// *** rtl/fp_exc_classify.sv ***
// Exception flag and compare code formation for one completing operation
`timescale 1ns/1ns
`default_nettype none
module fp_exc_classify (
	// Datapath condition flags
	input wire logic invalid_i,
	input wire logic overflow_i,
	input wire logic tiny_i,
	input wire logic inexact_i,
	input wire logic is_div_i,
	input wire logic divisor_zero_i,
	input wire logic dividend_zero_i,
	input wire logic dividend_finite_i,
	// Compare flags
	input wire logic cmp_signaling_i,
	input wire logic cmp_lt_i,
	input wire logic cmp_gt_i,
	input wire logic cmp_nan_i,
	// Results
	output logic [fp_state_pkg::EXC_W-1:0] exc_o,
	output fp_state_pkg::fcc_t fcc_o
);
	import fp_state_pkg::*;
	// Zero over zero is invalid, never divide-by-zero
	wire zero_by_zero = is_div_i & divisor_zero_i & dividend_zero_i;
	wire div_by_zero = is_div_i & divisor_zero_i & ~dividend_zero_i & dividend_finite_i;
	wire nv = invalid_i | zero_by_zero | (cmp_signaling_i & cmp_nan_i);
	// Order: invalid, overflow, underflow, divide-by-zero, inexact
	assign exc_o = {nv, overflow_i, tiny_i & inexact_i, div_by_zero, inexact_i};
	// Any NaN makes the relation unordered
	assign fcc_o = cmp_nan_i ? FCC_UNORD :
		cmp_lt_i ? FCC_LT :
		cmp_gt_i ? FCC_GT : FCC_EQ;
endmodule
`default_nettype wire

// *** rtl/fp_reg_file.sv ***
// Thirty-two word working register file with single, pair and quad access
`timescale 1ns/1ns
`default_nettype none
module fp_reg_file (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Operand read ports
	input wire logic [fp_state_pkg::FIDX_W-1:0] rd_a_idx_i,
	input wire fp_state_pkg::prec_t rd_a_prec_i,
	output logic [fp_state_pkg::OPND_W-1:0] rd_a_data_o,
	input wire logic [fp_state_pkg::FIDX_W-1:0] rd_b_idx_i,
	input wire fp_state_pkg::prec_t rd_b_prec_i,
	output logic [fp_state_pkg::OPND_W-1:0] rd_b_data_o,
	// Store read port
	input wire logic [fp_state_pkg::FIDX_W-1:0] st_idx_i,
	input wire logic st_dbl_i,
	output logic [fp_state_pkg::XFER_W-1:0] st_data_o,
	// Result write port
	input wire logic wr_en_i,
	input wire logic [fp_state_pkg::FIDX_W-1:0] wr_idx_i,
	input wire fp_state_pkg::prec_t wr_prec_i,
	input wire logic [fp_state_pkg::OPND_W-1:0] wr_data_i,
	// Load write port
	input wire logic ld_en_i,
	input wire logic [fp_state_pkg::FIDX_W-1:0] ld_idx_i,
	input wire logic ld_dbl_i,
	input wire logic [fp_state_pkg::XFER_W-1:0] ld_data_i
);
	import fp_state_pkg::*;
	logic [FREG_W-1:0] regs [FREG_NUM]; // Working registers
	// Aligned base index and word count per precision
	function automatic logic [FIDX_W-1:0] base_of(input logic [FIDX_W-1:0] idx,
		input prec_t p);
		base_of = (p == PREC_QUAD) ? {idx[FIDX_W-1:2], 2'h0} :
			(p == PREC_DOUBLE) ? {idx[FIDX_W-1:1], 1'h0} : idx;
	endfunction
	function automatic int words_of(input prec_t p);
		words_of = (p == PREC_QUAD) ? 4 : (p == PREC_DOUBLE) ? 2 : 1;
	endfunction
	prec_t st_prec;
	prec_t ld_prec;
	assign st_prec = st_dbl_i ? PREC_DOUBLE : PREC_SINGLE;
	assign ld_prec = ld_dbl_i ? PREC_DOUBLE : PREC_SINGLE;
	// Writes; on a shared word the one at the later word position k lands, the load on a tie
	always_ff @(posedge core_clk_i) begin
		for (int k = 0; k < 4; k++) begin
			if (wr_en_i && k < words_of(wr_prec_i)) begin
				regs[base_of(wr_idx_i, wr_prec_i) + FIDX_W'(k)] <= wr_data_i[OPND_W-1-32*k -: 32];
			end
			if (ld_en_i && k < words_of(ld_prec)) begin
				regs[base_of(ld_idx_i, ld_prec) + FIDX_W'(k)] <= ld_data_i[XFER_W-1-32*k -: 32];
			end
		end
	end
	// Registered reads, leading word in the top bits, unused words zero
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rd_a_data_o <= '0;
			rd_b_data_o <= '0;
			st_data_o <= '0;
		end else begin
			rd_a_data_o <= '0;
			rd_b_data_o <= '0;
			st_data_o <= '0;
			for (int k = 0; k < 4; k++) begin
				if (k < words_of(rd_a_prec_i)) begin
					rd_a_data_o[OPND_W-1-32*k -: 32] <= regs[base_of(rd_a_idx_i, rd_a_prec_i) + FIDX_W'(k)];
				end
				if (k < words_of(rd_b_prec_i)) begin
					rd_b_data_o[OPND_W-1-32*k -: 32] <= regs[base_of(rd_b_idx_i, rd_b_prec_i) + FIDX_W'(k)];
				end
				if (k < words_of(st_prec)) begin
					st_data_o[XFER_W-1-32*k -: 32] <= regs[base_of(st_idx_i, st_prec) + FIDX_W'(k)];
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** rtl/fp_state_and_exception_control.sv ***
// Floating-point state register, exception decision, queue and product extension
`timescale 1ns/1ns
`default_nettype none
module fp_state_and_exception_control (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Operate issue into the pending queue
	input wire logic issue_i,
	input wire logic [31:0] issue_addr_i,
	input wire logic [31:0] issue_instr_i,
	output logic issue_ready_o,
	// Fetch watch for sequence errors
	input wire logic fetch_fp_operate_i,
	input wire logic fetch_fpload_i,
	// Operate completion
	input wire logic done_i,
	input wire fp_state_pkg::done_status_t done_status_i,
	input wire logic done_is_cmp_i,
	input wire logic done_cmp_signaling_i,
	input wire logic done_wr_i,
	input wire logic [fp_state_pkg::FIDX_W-1:0] done_rd_i,
	input wire fp_state_pkg::prec_t done_prec_i,
	input wire logic [fp_state_pkg::OPND_W-1:0] done_data_i,
	// Completion condition flags
	input wire logic flag_invalid_i,
	input wire logic flag_overflow_i,
	input wire logic flag_tiny_i,
	input wire logic flag_inexact_i,
	input wire logic flag_div_i,
	input wire logic flag_divisor_zero_i,
	input wire logic flag_dividend_zero_i,
	input wire logic flag_dividend_finite_i,
	input wire logic cmp_lt_i,
	input wire logic cmp_gt_i,
	input wire logic cmp_nan_i,
	// Trap signalling
	output logic fp_trap_o,
	output fp_state_pkg::ftt_t trap_type_o,
	output logic exc_mode_o,
	// State register load and store
	input wire logic load_state_instr_i,
	input wire logic [31:0] load_state_data_i,
	output logic [31:0] fp_state_register_o,
	// Queue store
	input wire logic queue_store_instr_i,
	output logic [fp_state_pkg::XFER_W-1:0] queue_entry_o,
	output logic queue_entry_valid_o,
	// Operand reads
	input wire logic [fp_state_pkg::FIDX_W-1:0] rd_a_idx_i,
	input wire fp_state_pkg::prec_t rd_a_prec_i,
	output logic [fp_state_pkg::OPND_W-1:0] rd_a_data_o,
	input wire logic [fp_state_pkg::FIDX_W-1:0] rd_b_idx_i,
	input wire fp_state_pkg::prec_t rd_b_prec_i,
	output logic [fp_state_pkg::OPND_W-1:0] rd_b_data_o,
	// Floating-point loads and stores
	input wire logic fld_i,
	input wire logic [fp_state_pkg::FIDX_W-1:0] fld_idx_i,
	input wire logic fld_dbl_i,
	input wire logic [fp_state_pkg::XFER_W-1:0] fld_data_i,
	input wire logic [fp_state_pkg::FIDX_W-1:0] fst_idx_i,
	input wire logic fst_dbl_i,
	output logic [fp_state_pkg::XFER_W-1:0] fst_data_o,
	// Mode outputs to the arithmetic datapath
	output fp_state_pkg::round_dir_t round_dir_o,
	output fp_state_pkg::round_prec_t round_precision_o,
	output logic abrupt_underflow_o,
	// Product extension register
	input wire logic write_product_ext_i,
	input wire logic [31:0] write_product_ext_data_i,
	input wire logic multiply_step_instr_i,
	input wire logic multiply_step_lsb_i,
	output logic [31:0] product_extension_register_o
);
	import fp_state_pkg::*;

	// ****************************************
	// State register fields
	// ****************************************
	round_dir_t round_dir; // Rounding direction
	round_prec_t round_precision; // Extended rounding precision
	logic [EXC_W-1:0] trap_enable_mask; // Per-exception trap enables
	logic abrupt_underflow; // Flush denormal results
	ftt_t trap_type; // Last trap type
	logic [1:0] fcc; // Compare condition codes
	logic [EXC_W-1:0] aexc; // Accrued exceptions
	logic [EXC_W-1:0] cexc; // Current exceptions
	logic [31:0] product_ext; // Multiply-step extension
	fpu_state_t state; // Running or waiting for queue drain

	// ****************************************
	// Pending operation queue storage
	// ****************************************
	logic [XFER_W-1:0] queue_mem [QUEUE_DEPTH]; // Address and instruction pairs
	logic [QPTR_W-1:0] q_head; // Oldest entry
	logic [QPTR_W-1:0] q_tail; // Next free slot
	logic [QCNT_W-1:0] q_count; // Entries held

	// ****************************************
	// Completion classification
	// ****************************************
	logic [EXC_W-1:0] new_exc; // Exceptions of the completing operation
	fcc_t new_fcc; // Compare result code

	fp_exc_classify u_classify (
		.invalid_i(flag_invalid_i),
		.overflow_i(flag_overflow_i),
		.tiny_i(flag_tiny_i),
		.inexact_i(flag_inexact_i),
		.is_div_i(flag_div_i),
		.divisor_zero_i(flag_divisor_zero_i),
		.dividend_zero_i(flag_dividend_zero_i),
		.dividend_finite_i(flag_dividend_finite_i),
		.cmp_signaling_i(done_cmp_signaling_i),
		.cmp_lt_i(cmp_lt_i),
		.cmp_gt_i(cmp_gt_i),
		.cmp_nan_i(cmp_nan_i),
		.exc_o(new_exc),
		.fcc_o(new_fcc)
	);

	// ****************************************
	// Decision wires
	// ****************************************
	wire running = (state == ST_RUN);
	wire in_exc = (state == ST_EXC);
	// Completions only count while running
	wire op_ok = done_i & running & (done_status_i == DONE_OK);
	wire op_fail = done_i & running & (done_status_i != DONE_OK);
	// Enabled and raised exceptions force a trap
	wire ieee_trap = op_ok & (|(new_exc & trap_enable_mask));
	wire op_clean = op_ok & ~ieee_trap;
	wire any_trap = ieee_trap | op_fail;
	// Operate or load fetched while waiting for the drain
	wire seq_err = in_exc & (fetch_fp_operate_i | fetch_fpload_i);
	wire q_full = (q_count == QCNT_W'(QUEUE_DEPTH));
	wire q_empty = (q_count == '0);
	wire q_push = issue_i & issue_ready_o;
	// Front leaves on clean completion; a trapping one stays at the front
	wire q_pop_done = op_clean & ~q_empty;
	wire q_pop_store = in_exc & queue_store_instr_i & ~q_empty;
	wire q_pop = q_pop_done | q_pop_store;
	wire [QCNT_W-1:0] next_q_count = q_count + (q_push ? QCNT_ONE : '0) -
		(q_pop ? QCNT_ONE : '0);

	// ****************************************
	// Abrupt underflow flush of results
	// ****************************************
	wire [31:0] lead_word = done_data_i[OPND_W-1 -: 32];
	wire [31:0] exp_mask = (done_prec_i == PREC_QUAD) ? QUAD_EXP_MASK :
		(done_prec_i == PREC_DOUBLE) ? DBL_EXP_MASK : SGL_EXP_MASK;
	// A zero exponent marks a zero or denormal result
	wire flush = abrupt_underflow & ((lead_word & exp_mask) == '0);
	wire [OPND_W-1:0] wr_data = flush ? {lead_word & SIGN_MASK, {(OPND_W-32){1'b0}}} :
		done_data_i;
	// Results are written only when no trap condition exists
	wire wr_en = op_clean & done_wr_i & ~done_is_cmp_i;

	// ****************************************
	// Working register file
	// ****************************************
	fp_reg_file u_regs (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.rd_a_idx_i(rd_a_idx_i),
		.rd_a_prec_i(rd_a_prec_i),
		.rd_a_data_o(rd_a_data_o),
		.rd_b_idx_i(rd_b_idx_i),
		.rd_b_prec_i(rd_b_prec_i),
		.rd_b_data_o(rd_b_data_o),
		.st_idx_i(fst_idx_i),
		.st_dbl_i(fst_dbl_i),
		.st_data_o(fst_data_o),
		.wr_en_i(wr_en),
		.wr_idx_i(done_rd_i),
		.wr_prec_i(done_prec_i),
		.wr_data_i(wr_data),
		.ld_en_i(fld_i & running),
		.ld_idx_i(fld_idx_i),
		.ld_dbl_i(fld_dbl_i),
		.ld_data_i(fld_data_i)
	);

	// ****************************************
	// Mode fields, written only by a state load
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			round_dir <= round_dir_t'(FSR_RESET[RD_LO +: 2]);
			round_precision <= round_prec_t'(FSR_RESET[RP_LO +: 2]);
			trap_enable_mask <= FSR_RESET[TEM_LO +: EXC_W];
			abrupt_underflow <= FSR_RESET[AU_BIT];
		end else if (load_state_instr_i) begin
			round_dir <= round_dir_t'(load_state_data_i[RD_LO +: 2]);
			round_precision <= round_prec_t'(load_state_data_i[RP_LO +: 2]);
			// All five enables are real; each also reads back as loaded
			trap_enable_mask <= load_state_data_i[TEM_LO +: EXC_W];
			abrupt_underflow <= load_state_data_i[AU_BIT];
		end
	end

	// ****************************************
	// Trap type: set by hardware, never by a load
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			trap_type <= ftt_t'(FSR_RESET[FTT_LO +: 3]);
		end else if (seq_err) begin
			trap_type <= FTT_SEQ_ERR;
		end else if (op_fail) begin
			trap_type <= (done_status_i == DONE_UNIMPL) ? FTT_UNIMPL : FTT_UNFINISHED;
		end else if (ieee_trap) begin
			trap_type <= FTT_IEEE;
		end else if (op_ok) begin
			trap_type <= FTT_NONE;
		end
	end

	// ****************************************
	// Current exceptions
	// ****************************************
	// Completion wins over a load in the same cycle; failed ops leave it as it was
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cexc <= FSR_RESET[CEXC_LO +: EXC_W];
		end else if (op_ok) begin
			cexc <= new_exc;
		end else if (load_state_instr_i) begin
			cexc <= load_state_data_i[CEXC_LO +: EXC_W];
		end
	end

	// ****************************************
	// Accrued exceptions
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			aexc <= FSR_RESET[AEXC_LO +: EXC_W];
		end else if (op_clean) begin
			aexc <= aexc | new_exc;
		end else if (load_state_instr_i) begin
			aexc <= load_state_data_i[AEXC_LO +: EXC_W];
		end
	end

	// ****************************************
	// Compare condition codes
	// ****************************************
	// A compare updates them even when the signaling form traps
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			fcc <= FSR_RESET[FCC_LO +: 2];
		end else if (op_ok && done_is_cmp_i) begin
			fcc <= new_fcc;
		end else if (load_state_instr_i) begin
			fcc <= load_state_data_i[FCC_LO +: 2];
		end
	end

	// ****************************************
	// Exception mode state machine
	// ****************************************
	fpu_state_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (any_trap) begin
					next_state = ST_EXC;
				end
			end
			ST_EXC: begin
				// Leave once software has drained the queue
				if (next_q_count == '0) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state <= ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// Pending queue pointers and storage
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			q_head <= '0;
			q_tail <= '0;
			q_count <= '0;
		end else begin
			if (q_push) begin
				q_tail <= q_tail + QPTR_ONE;
			end
			if (q_pop) begin
				q_head <= q_head + QPTR_ONE;
			end
			q_count <= next_q_count;
		end
	end

	// Entry holds address above instruction word
	always_ff @(posedge core_clk_i) begin
		if (q_push) begin
			queue_mem[q_tail] <= {issue_addr_i, issue_instr_i};
		end
	end

	// Queue store hands out the front entry one cycle later
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			queue_entry_o <= '0;
			queue_entry_valid_o <= 1'b0;
		end else begin
			queue_entry_valid_o <= q_pop_store;
			if (q_pop_store) begin
				queue_entry_o <= queue_mem[q_head];
			end
		end
	end

	// ****************************************
	// Trap pulse
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			fp_trap_o <= 1'b0;
		end else begin
			fp_trap_o <= any_trap | seq_err;
		end
	end

	// ****************************************
	// Product extension register
	// ****************************************
	// Explicit write wins over a multiply step in the same cycle
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			product_ext <= PEXT_RESET;
		end else if (write_product_ext_i) begin
			product_ext <= write_product_ext_data_i;
		end else if (multiply_step_instr_i) begin
			product_ext <= {multiply_step_lsb_i, product_ext[31:1]};
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// New operations are held off while full or in exception mode
	assign issue_ready_o = running & ~q_full;
	assign exc_mode_o = in_exc;
	assign trap_type_o = trap_type;
	assign round_dir_o = round_dir;
	assign round_precision_o = round_precision;
	assign abrupt_underflow_o = abrupt_underflow;
	assign product_extension_register_o = product_ext;
	// Store image; reserved bits read as zero
	assign fp_state_register_o = {round_dir, round_precision, trap_enable_mask,
		abrupt_underflow, 5'h00, trap_type, ~q_empty, 1'b0, fcc, aexc, cexc};
endmodule
`default_nettype wire

// *** tb/fp_state_asserts.sv ***
// Concurrent checks on the floating-point state and exception block
`timescale 1ns/1ns
`default_nettype none
module fp_state_asserts (
	// Watched ports
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic done_i,
	input wire fp_state_pkg::done_status_t done_status_i,
	input wire logic exc_mode_o,
	input wire logic fp_trap_o,
	input wire logic fetch_fp_operate_i,
	input wire logic fetch_fpload_i,
	input wire logic load_state_instr_i,
	input wire logic [31:0] load_state_data_i,
	input wire logic [31:0] fp_state_register_o,
	input wire fp_state_pkg::round_dir_t round_dir_o,
	input wire logic write_product_ext_i,
	input wire logic multiply_step_instr_i,
	input wire logic multiply_step_lsb_i,
	input wire logic [31:0] product_extension_register_o
);
	import fp_state_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic [31:0] f = fp_state_register_o;
	wire logic [31:0] p = product_extension_register_o;
	// Accepted completion, no load beside it
	sequence s_done;
		done_i && !exc_mode_o && !load_state_instr_i;
	endsequence
	sequence s_ok;
		s_done ##0 done_status_i == DONE_OK;
	endsequence
	chk_trap_decide: assert property (s_ok |=> fp_trap_o == |(f[4:0] & f[27:23]))
		else $error("trap decision wrong");
	chk_trap_kind: assert property (s_ok |=> f[16:14] == (fp_trap_o ? 3'h1 : 3'h0))
		else $error("trap type wrong after completion");
	chk_accrue_or: assert property (s_ok |=> fp_trap_o || f[9:5] == ($past(f[9:5]) | f[4:0]))
		else $error("accrued field not merged");
	chk_trap_freeze: assert property (s_ok |=> !fp_trap_o || f[9:5] == $past(f[9:5]))
		else $error("accrued field changed on trap");
	chk_unfin_keep: assert property (s_done ##0 done_status_i != DONE_OK |=>
		fp_trap_o && f[16:14] == {1'b0, $past(done_status_i)} + 3'h1 && f[11:5] == $past(f[11:5]))
		else $error("unfinished completion mishandled");
	chk_load_keep: assert property (load_state_instr_i && !done_i |=>
		f[16:13] == $past(f[16:13]) && f[31:22] == $past(load_state_data_i[31:22]))
		else $error("state load wrong");
	chk_reserved_zero: assert property (f[21:17] == 5'h00 && !f[12])
		else $error("reserved bits not zero");
	chk_seq_error: assert property (exc_mode_o && (fetch_fp_operate_i || fetch_fpload_i) |=>
		fp_trap_o && f[16:14] == 3'h4)
		else $error("sequence error missed");
	chk_round_dir: assert property ($changed(round_dir_o) |-> $past(load_state_instr_i))
		else $error("rounding direction output wrong");
	chk_step_shift: assert property (multiply_step_instr_i && !write_product_ext_i |=>
		p == {$past(multiply_step_lsb_i), 31'h0000_0000} | ($past(p) >> 1))
		else $error("multiply step shift wrong");
endmodule
bind fp_state_and_exception_control fp_state_asserts i_chk (.*);
`default_nettype wire

// *** tb/iu_model.sv ***
// Integer unit model issuing one operate into the pending queue
`timescale 1ns/1ns
`default_nettype none
module iu_model (
	// Bench request
	input wire logic core_clk_i,
	input wire logic req_i,
	input wire logic [31:0] req_addr_i,
	// Issue handshake
	input wire logic issue_ready_o,
	output logic issue_i,
	output logic [31:0] issue_addr_i,
	output logic [31:0] issue_instr_i
);
	initial {issue_i, issue_addr_i, issue_instr_i} = '0;
	// Hold the issue until ready is sampled; idle lines keep toggling
	always @(posedge core_clk_i) begin
		if (!issue_i) {issue_addr_i, issue_instr_i} <= ~{issue_addr_i, issue_instr_i};
		if (issue_i && issue_ready_o) issue_i <= 1'b0;
		else if (req_i && !issue_i) {issue_i, issue_addr_i, issue_instr_i} <= {1'b1, req_addr_i, ~req_addr_i};
	end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the floating-point state and exception block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import fp_state_pkg::*;
	logic core_clk_i = 0, rst_n_i = 0, req_i = 0, issue_i, issue_ready_o, fp_trap_o, exc_mode_o;
	logic fetch_fp_operate_i = 0, fetch_fpload_i = 0, done_i = 0, done_is_cmp_i = 0, done_wr_i = 0;
	logic done_cmp_signaling_i = 0, cmp_lt_i = 0, cmp_gt_i = 0, cmp_nan_i = 0;
	logic flag_invalid_i = 0, flag_overflow_i = 0, flag_tiny_i = 0, flag_inexact_i = 0;
	logic flag_div_i = 0, flag_divisor_zero_i = 0, flag_dividend_zero_i = 0, flag_dividend_finite_i = 0;
	logic load_state_instr_i = 0, queue_store_instr_i = 0, queue_entry_valid_o, abrupt_underflow_o;
	logic fld_i = 0, fld_dbl_i = 1, fst_dbl_i = 1, write_product_ext_i = 0, multiply_step_instr_i = 0;
	logic multiply_step_lsb_i = 0;
	logic [4:0] done_rd_i = '0, rd_a_idx_i = '0, rd_b_idx_i = '0, fld_idx_i = 5'h03, fst_idx_i = 5'h02;
	logic [31:0] req_addr_i = '0, issue_addr_i, issue_instr_i, load_state_data_i = '0, fp_state_register_o;
	logic [31:0] write_product_ext_data_i = '0, product_extension_register_o, m = '0, p = '0;
	logic [63:0] queue_entry_o, fld_data_i = '0, fst_data_o, f;
	logic [127:0] done_data_i = '0, rd_a_data_o, rd_b_data_o;
	logic [127:0] q[$];
	done_status_t done_status_i = DONE_OK;
	prec_t done_prec_i = PREC_SINGLE, rd_a_prec_i = PREC_QUAD, rd_b_prec_i = PREC_DOUBLE;
	ftt_t trap_type_o;
	round_dir_t round_dir_o;
	round_prec_t round_precision_o;
	int fail_count = 0, compares = 0;
	fp_state_and_exception_control i_dut (.*);
	iu_model i_iu (.*);
	initial forever #20 core_clk_i = ~core_clk_i;
	task automatic chk(input logic [127:0] s, input logic [127:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %0t %h %h", $time, s, e);
		end
	endtask
	task automatic wrap_up();
		if (fail_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// One cycle passes; pulses drop and the expected image is noted
	task automatic tick();
		@(negedge core_clk_i);
		{done_i, load_state_instr_i, fld_i, fetch_fp_operate_i, fetch_fpload_i} = '0;
		{queue_store_instr_i, write_product_ext_i, multiply_step_instr_i} = '0;
		{rd_a_idx_i, rd_b_idx_i} = {5'($urandom), 4'h1, 1'($urandom)};
		q.push_back({p, m, f});
	endtask
	task automatic load(input logic [31:0] d);
		load_state_data_i = d;
		load_state_instr_i = 1;
		m = (m & 32'h0001_E000) | (d & 32'hFFC0_0FFF);
		tick();
	endtask
	// Completion with exceptions x, status st and compare code k
	task automatic fin(input logic [4:0] x, input logic [1:0] st, input logic [2:0] k);
		logic [4:0] e;
		logic t;
		e = x | {4'h0, x[2]};
		{flag_invalid_i, flag_overflow_i, flag_tiny_i, flag_inexact_i} = {x[4:2], x[0] | x[2]};
		{flag_div_i, flag_divisor_zero_i, flag_dividend_finite_i} = {3{x[1]}};
		{done_is_cmp_i, cmp_nan_i, cmp_gt_i, cmp_lt_i} = {k[2], k[1:0] == 3, k[1:0] == 2, k[1:0] == 1};
		{done_wr_i, done_rd_i, done_data_i} = {1'b1, 5'h10 | 5'($urandom), {4{$urandom}}};
		done_status_i = done_status_t'(st);
		done_i = 1;
		t = st != 0 || |(e & m[27:23]);
		if (st != 0) m[16:14] = {1'b0, st} + 3'h1;
		else begin
			m[4:0] = e;
			if (k[2]) m[11:10] = k[1:0];
			if (t) m[16:14] = 3'h1;
			else {m[16:14], m[9:5]} = {3'h0, m[9:5] | e};
		end
		tick();
		if (t && !m[13]) @(negedge core_clk_i);
	endtask
	always @(negedge core_clk_i) begin
		#1;
		if (q.size() > 0) chk({product_extension_register_o, fp_state_register_o, fst_data_o}, q.pop_front());
	end
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (6) @(negedge core_clk_i);
		rst_n_i = 1;
		void'($urandom(32'h3c04));
		{fld_data_i, fld_i} = {$urandom, $urandom, 1'b1};
		f = fld_data_i;
		@(negedge core_clk_i);
		tick();
		for (int i = 0; i < 4; i++) load(($urandom & 32'h3FC1_EFFF) | (i << 30));
		load(32'h0000_0000);
		for (int i = 0; i < 5; i++) fin(5'h01 << i, 2'h0, {1'b1, 2'(i)});
		load(32'h0080_0000);
		fin(5'h01, 2'h0, 3'h5);
		fin(5'h10, 2'h0, 3'h0);
		fin(5'h00, 2'h1, 3'h0);
		fin(5'h00, 2'h2, 3'h0);
		{req_i, req_addr_i} = {1'b1, $urandom};
		@(negedge core_clk_i);
		req_i = 0;
		m[13] = 1;
		tick();
		fin(5'h01, 2'h0, 3'h0);
		{fetch_fp_operate_i, fetch_fpload_i} = 2'h3;
		m[16:14] = 3'h4;
		tick();
		queue_store_instr_i = 1;
		m[13] = 0;
		tick();
		chk({63'h0, queue_entry_valid_o, queue_entry_o}, {64'h1, req_addr_i, ~req_addr_i});
		chk(rd_b_data_o, {f, 64'h0});
		{write_product_ext_i, write_product_ext_data_i} = {1'b1, $urandom};
		p = write_product_ext_data_i;
		tick();
		repeat (3) begin
			{multiply_step_instr_i, multiply_step_lsb_i} = {1'b1, 1'($urandom)};
			p = {multiply_step_lsb_i, p[31:1]};
			tick();
		end
		@(negedge core_clk_i);
		wrap_up();
	end
endmodule
`default_nettype wire
